// *** rtl/nibble_core_pkg.sv ***
`default_nettype none
package nibble_core_pkg;

  localparam int INSTR_W           = 10;
  localparam int PC_LOW_W          = 7;
  localparam int PAGE_W_MIN        = 4;
  localparam int PAGE_W_MAX        = 5;
  localparam int PORT_D_W_DEFAULT  = 6;
  localparam int PORT_D_W_MAX      = 16;
  localparam int STACK_DEPTH       = 8;
  localparam int SP_W              = 3;
  localparam int APB_ADDR_W        = 8;
  localparam int CALL_PAGE         = 2;
  localparam int CONV_MODE_BIT     = 3;
  localparam int CTRL_RUN_BIT      = 0;
  localparam int ACC_CARRY_BIT     = 4;
  localparam int CONV_DONE_BIT     = 4;

  // register byte offsets
  localparam logic [APB_ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [APB_ADDR_W-1:0] REG_ACC    = 8'h04;
  localparam logic [APB_ADDR_W-1:0] REG_PTR    = 8'h08;
  localparam logic [APB_ADDR_W-1:0] REG_CONV   = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [APB_ADDR_W-1:0] REG_PC     = 8'h14;
  localparam logic [APB_ADDR_W-1:0] REG_PORTD  = 8'h18;
  localparam logic [APB_ADDR_W-1:0] REG_STACK  = 8'h1c;

  localparam logic [SP_W-1:0] RESET_SP        = 3'h7;
  localparam logic [3:0]      RESET_CONV_CTRL = 4'h0;
  localparam logic [3:0]      Y_WRAP          = 4'hf;

  // instruction codes and match masks
  localparam logic [INSTR_W-1:0] MASK_FULL = 10'h3ff;
  localparam logic [INSTR_W-1:0] MASK_NIB  = 10'h3f0;
  localparam logic [INSTR_W-1:0] MASK_A7   = 10'h380;
  localparam logic [INSTR_W-1:0] MASK_P5   = 10'h3e0;
  localparam logic [INSTR_W-1:0] OP_ADD_IMM                = 10'h060;
  localparam logic [INSTR_W-1:0] OP_CONVERSION_LAUNCH      = 10'h29f;
  localparam logic [INSTR_W-1:0] OP_MEMORY_ADD             = 10'h00a;
  localparam logic [INSTR_W-1:0] OP_MEMORY_ADD_CARRY       = 10'h00b;
  localparam logic [INSTR_W-1:0] OP_NEAR_JUMP              = 10'h180;
  localparam logic [INSTR_W-1:0] OP_FAR_JUMP               = 10'h0e0;
  localparam logic [INSTR_W-1:0] OP_COMPUTED_FAR_JUMP      = 10'h010;
  localparam logic [INSTR_W-1:0] OP_PAGE_TWO_CALL          = 10'h100;
  localparam logic [INSTR_W-1:0] OP_FAR_CALL               = 10'h0c0;
  localparam logic [INSTR_W-1:0] OP_COMPUTED_FAR_CALL      = 10'h030;
  localparam logic [INSTR_W-1:0] OP_PORT_D_SET             = 10'h011;
  localparam logic [INSTR_W-1:0] OP_ACCUMULATOR_INVERT     = 10'h01c;
  localparam logic [INSTR_W-1:0] OP_RESONATOR_CLOCK_SELECT = 10'h29a;
  localparam logic [INSTR_W-1:0] OP_RC_CLOCK_SELECT        = 10'h29b;
  localparam logic [INSTR_W-1:0] OP_Y_POINTER_DECREMENT    = 10'h017;
  localparam logic [INSTR_W-1:0] OP_IRQ_DISABLE            = 10'h004;
  localparam logic [INSTR_W-1:0] OP_IRQ_ENABLE             = 10'h005;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_STOP_ARM      = 10'h29c;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_RESTART       = 10'h2a0;
  localparam logic [INSTR_W-1:0] OP_POWERDOWN_UNLOCK       = 10'h05b;
  localparam logic [INSTR_W-1:0] OP_POWERDOWN_WITH_VDET    = 10'h002;
  localparam logic [INSTR_W-1:0] OP_POWERDOWN_PLAIN        = 10'h008;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'b001,
    ST_WORD2  = 3'b010,
    ST_BACKUP = 3'b100
  } core_state_t;

endpackage : nibble_core_pkg
`default_nettype wire

// *** rtl/nibble_adder.sv ***
`timescale 1ns/1ps
`default_nettype none
module nibble_adder (
  input  wire logic [3:0] a_i,
  input  wire logic [3:0] b_i,
  input  wire logic       carry_i,
  output logic      [3:0] sum_o,
  output logic            carry_o
);
  logic [4:0] total;

  assign total   = {1'b0, a_i} + {1'b0, b_i} + {4'h0, carry_i};
  assign sum_o   = total[3:0];
  assign carry_o = total[4];
endmodule : nibble_adder
`default_nettype wire

// *** rtl/return_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
  parameter int WIDTH = 12
) (
  input  wire logic                                clk_i,
  input  wire logic                                arst_n_i,
  input  wire logic                                push_i,
  input  wire logic [WIDTH-1:0]                    data_i,
  output logic      [nibble_core_pkg::SP_W-1:0]   sp_o,
  output logic      [WIDTH-1:0]                    top_o
);
  import nibble_core_pkg::*;

  if (WIDTH < 1 || 2**SP_W != STACK_DEPTH) begin : g_bad_shape
    $error("return stack shape unsupported");
  end

  logic [WIDTH-1:0] entry [STACK_DEPTH];
  logic [SP_W-1:0]  next_sp;

  // pointer moves and the entry it will point at is written on the same edge
  assign next_sp = sp_o + 3'h1;
  assign top_o   = entry[sp_o];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_o <= RESET_SP;
    end else if (push_i) begin
      sp_o <= next_sp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_i) begin
      entry[next_sp] <= data_i;
    end
  end
endmodule : return_stack
`default_nettype wire

// *** rtl/nibble_core.sv ***
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - immediate add, carry kept, skip without overflow
// - launch clears done flag, mode bit picks
// - memory add into accumulator, carry kept
// - near jump replaces low seven bits
// - far jump/call two words, call pushes
// - one-word call into page two, pushes
// - port D set to all ones
// - invert accumulator, no carry change, no skip
// - interrupt enable change acts one cycle later
// - enable sets flag, disable clears flag
// - stop arm, restart then stops watchdog
// - restart skips only when the watchdog flag is set, and clears that flag
// - power-down needs prior unlock instruction
// - two power-down variants, with/without detector
// - skip invalidates next word, no double step
// - page field four or five bits wide
module nibble_core #(
  parameter int PAGE_W   = nibble_core_pkg::PAGE_W_MAX,
  parameter int PORT_D_W = nibble_core_pkg::PORT_D_W_DEFAULT
) (
  input  wire logic                                           CLK_SYS_I,
  input  wire logic                                           ARST_N_I,
  input  wire logic                                           PSEL_I,
  input  wire logic                                           PENABLE_I,
  input  wire logic                                           PWRITE_I,
  input  wire logic [nibble_core_pkg::APB_ADDR_W-1:0]         PADDR_I,
  input  wire logic [31:0]                                    PWDATA_I,
  output logic      [31:0]                                    PRDATA_O,
  output logic                                                PREADY_O,
  output logic                                                PSLVERR_O,
  output logic      [PAGE_W+nibble_core_pkg::PC_LOW_W-1:0]    ROM_ADDR_O,
  input  wire logic [nibble_core_pkg::INSTR_W-1:0]            ROM_DATA_I,
  output logic      [7:0]                                     RAM_ADDR_O,
  input  wire logic [3:0]                                     RAM_DATA_I,
  output logic      [PORT_D_W-1:0]                            PORT_D_O,
  output logic                                                CONV_START_O,
  output logic                                                CMP_START_O,
  input  wire logic                                           ADC_DONE_I,
  input  wire logic                                           WDT_FLAG_SET_I,
  output logic                                                WDT_STOP_O,
  output logic                                                CLK_RES_SEL_O,
  output logic                                                CLK_RC_SEL_O,
  output logic                                                OSC_STOP_O,
  output logic                                                INT_ENABLE_O,
  output logic                                                INT_ACCEPT_EN_O,
  output logic                                                BACKUP_O,
  output logic                                                VDET_KEEP_O
);
  import nibble_core_pkg::*;

  localparam int PC_W = PAGE_W + PC_LOW_W;

  if (PAGE_W < PAGE_W_MIN || PAGE_W > PAGE_W_MAX) begin : g_bad_page
    $error("PAGE_W must be 4 or 5");
  end
  if (PORT_D_W < 1 || PORT_D_W > PORT_D_W_MAX) begin : g_bad_port
    $error("PORT_D_W out of range");
  end

  function automatic logic op_is(input logic [INSTR_W-1:0] w, code, mask);
    return (w & mask) == code;
  endfunction

  core_state_t        state;
  core_state_t        next_state;
  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    next_pc;
  logic [3:0]         acc;
  logic [3:0]         next_acc;
  logic [3:0]         y;
  logic [3:0]         next_y;
  logic [3:0]         x;
  logic [2:0]         dr;
  logic [3:0]         conv_ctrl;
  logic               carry;
  logic               next_carry;
  logic               skip;
  logic               next_skip;
  logic               run;
  logic [PAGE_W-1:0]  pend_page;
  logic               pend_call;
  logic               pend_computed;
  logic               wdt_armed;
  logic               watchdog_flag_one;
  logic               pd_unlock;
  logic               conv_done;
  logic [SP_W-1:0]    sp;
  logic [PC_W-1:0]    stack_top;

  // instruction decode
  wire [INSTR_W-1:0] ins     = ROM_DATA_I;
  wire exec                  = (state == ST_FETCH) && run && !skip;
  wire op_add_imm = exec && op_is(ins, OP_ADD_IMM, MASK_NIB);
  wire op_conversion_launch_op    = exec && op_is(ins, OP_CONVERSION_LAUNCH, MASK_FULL);
  wire op_am      = exec && op_is(ins, OP_MEMORY_ADD, MASK_FULL);
  wire op_amc     = exec && op_is(ins, OP_MEMORY_ADD_CARRY, MASK_FULL);
  wire op_b       = exec && op_is(ins, OP_NEAR_JUMP, MASK_A7);
  wire op_bl      = exec && op_is(ins, OP_FAR_JUMP, MASK_P5);
  wire op_bla     = exec && op_is(ins, OP_COMPUTED_FAR_JUMP, MASK_FULL);
  wire op_bm      = exec && op_is(ins, OP_PAGE_TWO_CALL, MASK_A7);
  wire op_bml     = exec && op_is(ins, OP_FAR_CALL, MASK_P5);
  wire op_computed_far_call_op    = exec && op_is(ins, OP_COMPUTED_FAR_CALL, MASK_FULL);
  wire op_cld     = exec && op_is(ins, OP_PORT_D_SET, MASK_FULL);
  wire op_cma     = exec && op_is(ins, OP_ACCUMULATOR_INVERT, MASK_FULL);
  wire op_resonator_clock_select_op    = exec && op_is(ins, OP_RESONATOR_CLOCK_SELECT, MASK_FULL);
  wire op_rc_clock_select_op    = exec && op_is(ins, OP_RC_CLOCK_SELECT, MASK_FULL);
  wire op_dey     = exec && op_is(ins, OP_Y_POINTER_DECREMENT, MASK_FULL);
  wire op_di      = exec && op_is(ins, OP_IRQ_DISABLE, MASK_FULL);
  wire op_ei      = exec && op_is(ins, OP_IRQ_ENABLE, MASK_FULL);
  wire op_watchdog_stop_arm_op    = exec && op_is(ins, OP_WATCHDOG_STOP_ARM, MASK_FULL);
  wire op_watchdog_restart_op    = exec && op_is(ins, OP_WATCHDOG_RESTART, MASK_FULL);
  wire op_powerdown_unlock_op    = exec && op_is(ins, OP_POWERDOWN_UNLOCK, MASK_FULL);
  wire op_pof     = exec && op_is(ins, OP_POWERDOWN_WITH_VDET, MASK_FULL);
  wire op_powerdown_plain_op    = exec && op_is(ins, OP_POWERDOWN_PLAIN, MASK_FULL);
  wire far_op     = op_bl || op_bla || op_bml || op_computed_far_call_op;
  wire pd_enter   = (op_pof || op_powerdown_plain_op) && pd_unlock;

  // arithmetic
  wire [3:0] add_b   = op_add_imm ? ins[3:0] : RAM_DATA_I;
  wire       add_cin = op_amc && carry;
  wire [3:0] sum;
  wire       cout;
  wire [3:0] y_dec   = 4'(y - 4'h1);

  nibble_adder u_adder (
    .a_i     (acc),
    .b_i     (add_b),
    .carry_i (add_cin),
    .sum_o   (sum),
    .carry_o (cout)
  );

  // branch targets
  wire [PC_W-1:0]     pc_inc      = PC_W'(pc + 1'b1);
  wire [PAGE_W-1:0]   word1_page  = PAGE_W'(ins[4:0]);
  wire [PAGE_W-1:0]   word2_page  = PAGE_W'({ins[6], ins[3:0]});
  wire [PC_LOW_W-1:0] calc_low    = {dr, acc};
  wire [PC_LOW_W-1:0] far_low     = pend_computed ? calc_low : ins[PC_LOW_W-1:0];
  wire [PAGE_W-1:0]   far_page    = pend_computed ? word2_page : pend_page;
  wire                in_word2    = (state == ST_WORD2);
  wire                push        = op_bm || (in_word2 && pend_call);

  return_stack #(
    .WIDTH (PC_W)
  ) u_stack (
    .clk_i    (CLK_SYS_I),
    .arst_n_i (ARST_N_I),
    .push_i   (push),
    .data_i   (pc_inc),
    .sp_o     (sp),
    .top_o    (stack_top)
  );

  // apb decode
  wire setup    = PSEL_I && !PENABLE_I;
  wire wr_fire  = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  wire hit_ctrl = (PADDR_I == REG_CTRL);
  wire hit_acc  = (PADDR_I == REG_ACC);
  wire hit_ptr  = (PADDR_I == REG_PTR);
  wire hit_conv = (PADDR_I == REG_CONV);
  wire hit_stat = (PADDR_I == REG_STATUS);
  wire hit_pc   = (PADDR_I == REG_PC);
  wire hit_pd   = (PADDR_I == REG_PORTD);
  wire hit_stk  = (PADDR_I == REG_STACK);
  wire mapped   = hit_ctrl | hit_acc | hit_ptr | hit_conv | hit_stat | hit_pc | hit_pd | hit_stk;
  wire wr_ctrl  = wr_fire && hit_ctrl;
  wire wr_acc   = wr_fire && hit_acc;
  wire wr_ptr   = wr_fire && hit_ptr;
  wire wr_conv  = wr_fire && hit_conv;
  wire [31:0] status_word = {21'h0, CLK_RC_SEL_O, CLK_RES_SEL_O, OSC_STOP_O, VDET_KEEP_O,
                             BACKUP_O, pd_unlock, watchdog_flag_one, WDT_STOP_O, wdt_armed,
                             INT_ACCEPT_EN_O, INT_ENABLE_O};
  wire [31:0] rd_word =
      hit_ctrl ? {31'h0, run} :
      hit_acc  ? {27'h0, carry, acc} :
      hit_ptr  ? {21'h0, dr, x, y} :
      hit_conv ? {27'h0, conv_done, conv_ctrl} :
      hit_stat ? status_word :
      hit_pc   ? {5'h0, state, 5'h0, sp, 16'(pc)} :
      hit_pd   ? 32'(PORT_D_O) :
      hit_stk  ? 32'(stack_top) : 32'h0;

  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_acc   = acc;
    next_carry = carry;
    next_y     = y;
    next_skip  = skip;
    unique case (state)
      ST_FETCH: begin
        if (run) begin
          next_pc   = pc_inc;
          next_skip = 1'b0;
          if (op_add_imm) begin
            next_acc  = sum;
            next_skip = !cout;
          end
          if (op_am) begin
            next_acc = sum;
          end
          if (op_amc) begin
            next_acc   = sum;
            next_carry = cout;
          end
          if (op_cma) begin
            next_acc = ~acc;
          end
          if (op_dey) begin
            next_y    = y_dec;
            next_skip = (y_dec == Y_WRAP);
          end
          if (op_watchdog_restart_op) begin
            next_skip = watchdog_flag_one;
          end
          if (op_b) begin
            next_pc = {pc[PC_W-1:PC_LOW_W], ins[PC_LOW_W-1:0]};
          end
          if (op_bm) begin
            next_pc = {PAGE_W'(CALL_PAGE), ins[PC_LOW_W-1:0]};
          end
          if (far_op) begin
            next_state = ST_WORD2;
          end
          if (pd_enter) begin
            next_state = ST_BACKUP;
          end
        end
      end
      ST_WORD2: begin
        next_pc    = {far_page, far_low};
        next_state = ST_FETCH;
      end
      ST_BACKUP: begin
        if (wr_ctrl) begin
          next_state = ST_FETCH;
        end
      end
    endcase
    if (wr_acc) begin
      next_acc   = PWDATA_I[3:0];
      next_carry = PWDATA_I[ACC_CARRY_BIT];
    end
    if (wr_ptr) begin
      next_y = PWDATA_I[3:0];
    end
  end

  assign ROM_ADDR_O = pc;
  assign RAM_ADDR_O = {x, y};

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= ST_FETCH;
      pc    <= '0;
      acc   <= 4'h0;
      carry <= 1'b0;
      y     <= 4'h0;
      skip  <= 1'b0;
    end else begin
      state <= next_state;
      pc    <= next_pc;
      acc   <= next_acc;
      carry <= next_carry;
      y     <= next_y;
      skip  <= next_skip;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pend_page     <= '0;
      pend_call     <= 1'b0;
      pend_computed <= 1'b0;
    end else if (far_op) begin
      pend_page     <= word1_page;
      pend_call     <= op_bml || op_computed_far_call_op;
      pend_computed <= op_bla || op_computed_far_call_op;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      run       <= 1'b0;
      x         <= 4'h0;
      dr        <= 3'h0;
      conv_ctrl <= RESET_CONV_CTRL;
    end else begin
      if (wr_ctrl) run <= PWDATA_I[CTRL_RUN_BIT];
      if (wr_ptr) x <= PWDATA_I[7:4];
      if (wr_ptr) dr <= PWDATA_I[10:8];
      if (wr_conv) conv_ctrl <= PWDATA_I[3:0];
    end
  end

  // hardware set wins over instruction clear
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      conv_done    <= 1'b0;
      CONV_START_O <= 1'b0;
      CMP_START_O  <= 1'b0;
      watchdog_flag_one         <= 1'b0;
      wdt_armed    <= 1'b0;
      WDT_STOP_O   <= 1'b0;
    end else begin
      conv_done    <= ADC_DONE_I || (conv_done && !op_conversion_launch_op);
      CONV_START_O <= op_conversion_launch_op && !conv_ctrl[CONV_MODE_BIT];
      CMP_START_O  <= op_conversion_launch_op && conv_ctrl[CONV_MODE_BIT];
      watchdog_flag_one         <= WDT_FLAG_SET_I || (watchdog_flag_one && !op_watchdog_restart_op);
      wdt_armed    <= wdt_armed || op_watchdog_stop_arm_op;
      WDT_STOP_O   <= WDT_STOP_O || (op_watchdog_restart_op && wdt_armed);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      INT_ENABLE_O    <= 1'b0;
      INT_ACCEPT_EN_O <= 1'b0;
      PORT_D_O        <= '0;
      CLK_RES_SEL_O   <= 1'b0;
      CLK_RC_SEL_O    <= 1'b0;
      OSC_STOP_O      <= 1'b0;
    end else begin
      INT_ENABLE_O    <= op_ei || (INT_ENABLE_O && !op_di);
      INT_ACCEPT_EN_O <= INT_ENABLE_O;
      if (op_cld) PORT_D_O <= '1;
      if (op_resonator_clock_select_op || op_rc_clock_select_op) begin
        CLK_RES_SEL_O <= op_resonator_clock_select_op;
        CLK_RC_SEL_O  <= op_rc_clock_select_op;
        OSC_STOP_O    <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pd_unlock   <= 1'b0;
      BACKUP_O    <= 1'b0;
      VDET_KEEP_O <= 1'b0;
    end else begin
      if (exec) pd_unlock <= op_powerdown_unlock_op;
      BACKUP_O <= (next_state == ST_BACKUP);
      if (pd_enter) VDET_KEEP_O <= op_pof;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
    end else begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup && !mapped;
      PRDATA_O  <= (setup && !PWRITE_I) ? rd_word : 32'h0;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  property p_add_imm;
    op_add_imm && !wr_acc |=> acc == $past(sum) && carry == $past(carry) && skip == !$past(cout);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("immediate add wrong");

  property p_launch;
    op_conversion_launch_op && !ADC_DONE_I |=> !conv_done && (CONV_START_O != CMP_START_O)
      && CMP_START_O == $past(conv_ctrl[CONV_MODE_BIT]);
  endproperty
  a_launch: assert property (p_launch) else $error("launch wrong");

  property p_mem_add;
    op_am && !wr_acc |=> acc == 4'($past(acc) + $past(RAM_DATA_I)) && carry == $past(carry);
  endproperty
  a_mem_add: assert property (p_mem_add) else $error("memory add wrong");

  property p_mem_add_carry;
    op_amc && !wr_acc |=> {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(RAM_DATA_I)}
      + {4'h0, $past(carry)};
  endproperty
  a_mem_add_carry: assert property (p_mem_add_carry) else $error("carry add wrong");

  property p_near_jump;
    op_b |=> pc == {$past(pc[PC_W-1:PC_LOW_W]), $past(ins[PC_LOW_W-1:0])};
  endproperty
  a_near_jump: assert property (p_near_jump) else $error("near jump wrong");

  property p_far_two_cycles;
    far_op |=> in_word2 ##1 state == ST_FETCH;
  endproperty
  a_far_two_cycles: assert property (p_far_two_cycles) else $error("far op timing");

  property p_page_two_call;
    op_bm |=> pc[PC_W-1:PC_LOW_W] == PAGE_W'(CALL_PAGE) && sp == 3'($past(sp) + 3'h1)
      && stack_top == $past(pc_inc);
  endproperty
  a_page_two_call: assert property (p_page_two_call) else $error("page call wrong");

  property p_port_d;
    op_cld |=> &PORT_D_O;
  endproperty
  a_port_d: assert property (p_port_d) else $error("port D not set");

  property p_dey;
    op_dey && !wr_ptr |=> y == 4'($past(y) - 4'h1) && skip == ($past(y) == 4'h0);
  endproperty
  a_dey: assert property (p_dey) else $error("decrement wrong");

  property p_irq_delay;
    op_ei && !INT_ENABLE_O |=> INT_ENABLE_O && !INT_ACCEPT_EN_O ##1 INT_ACCEPT_EN_O;
  endproperty
  a_irq_delay: assert property (p_irq_delay) else $error("enable delay wrong");

  property p_no_unlock;
    (op_pof || op_powerdown_plain_op) && !pd_unlock |=> !BACKUP_O;
  endproperty
  a_no_unlock: assert property (p_no_unlock) else $error("locked power-down");

  property p_skip_step;
    state == ST_FETCH && run && skip |=> pc == PC_W'($past(pc) + 1'b1) && !skip;
  endproperty
  a_skip_step: assert property (p_skip_step) else $error("skip stepping wrong");

  c_far_call: cover property (op_bml ##1 in_word2 ##1 push == 1'b0);
  c_backup: cover property (op_powerdown_unlock_op ##1 op_pof ##1 BACKUP_O);
  c_skip: cover property (op_add_imm ##1 skip);
endmodule : nibble_core
`default_nettype wire

// *** tb/prog_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
module prog_rom #(
  parameter int AW = 12
) (
  input  wire logic [AW-1:0] addr_i,
  output logic      [9:0]    data_o
);
  logic [9:0] mem [2**AW];
  // combinational read, word ready in the same cycle
  assign data_o = mem[addr_i];
endmodule : prog_rom
`default_nettype wire

// *** tb/nibble_cpu_exec_subset_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module nibble_cpu_exec_subset_test;
  import nibble_core_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, pen = 0, pw = 0, adc = 0, wdf = 0, ie_q = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwd = 0, prdata, rd_v;
  logic [11:0] rom_a;
  logic [9:0]  rom_d, prog[$];
  logic [7:0]  ram_a;
  logic        pready, pslverr, conv, cmp, wstop, ostop, rcsel, ien, iacc, bkup, vkeep, err_v;
  logic        ressel;
  int          bad_count = 0, num_checks = 0, conv_n = 0, cmp_n = 0, res_n = 0;
  wire  [3:0]  ram_d = ram_a[3:0] ^ 4'h5;

  always #50 clk = ~clk;

  nibble_core #(.PAGE_W(5), .PORT_D_W(6)) DUT (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ROM_ADDR_O(rom_a), .ROM_DATA_I(rom_d), .RAM_ADDR_O(ram_a),
    .RAM_DATA_I(ram_d), .PORT_D_O(), .CONV_START_O(conv), .CMP_START_O(cmp),
    .ADC_DONE_I(adc), .WDT_FLAG_SET_I(wdf), .WDT_STOP_O(wstop), .CLK_RES_SEL_O(ressel),
    .CLK_RC_SEL_O(rcsel), .OSC_STOP_O(ostop), .INT_ENABLE_O(ien),
    .INT_ACCEPT_EN_O(iacc), .BACKUP_O(bkup), .VDET_KEEP_O(vkeep));

  prog_rom #(.AW(12)) rom (.addr_i(rom_a), .data_o(rom_d));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pw <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_v, exp);
  endtask : rd

  task restart;
    arst_n <= 1'b0;
    for (int i = 0; i < 4096; i++) rom.mem[i] = 10'h000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    conv_n = 0;
    cmp_n = 0;
    res_n = 0;
    @(posedge clk);
  endtask : restart

  task load(input int base);
    foreach (prog[i]) rom.mem[base+i] = prog[i];
  endtask : load

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // launch pulse and resonator select counts, and acceptance lag of the enable flag
  always @(posedge clk) begin
    if (conv === 1'b1) conv_n++;
    if (cmp === 1'b1) cmp_n++;
    if (ressel === 1'b1) res_n++;
    if (arst_n === 1'b1) check({31'h0, iacc}, {31'h0, ie_q});
    ie_q <= arst_n ? ien : 1'b0;
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    wrap_up;
  end

  initial begin
    restart;
    prog = '{10'h017, 10'h065, 10'h063, 10'h06f, 10'h061, 10'h01c, 10'h01c, 10'h00a,
             10'h00b, 10'h011, 10'h005, 10'h29f, 10'h05b, 10'h002};
    load(0);
    apb(1'b1, REG_ACC, 32'h0e);
    apb(1'b1, REG_PTR, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    rd(REG_ACC, 32'h12);
    rd(REG_PTR, 32'h0f);
    rd(REG_STATUS, 32'hc3);
    apb(1'b1, REG_PORTD, 32'h0);
    rd(REG_PORTD, 32'h3f);
    rd(8'h20, 32'h0);
    check({31'h0, err_v}, 32'h1);
    check({30'h0, bkup, vkeep}, 32'h3);
    check(conv_n, 1);
    $display("test 1 done");
    restart;
    // call nesting stays at three levels
    prog = '{10'h0c1, 10'h205};
    load(0);
    prog = '{10'h110};
    load(12'h085);
    prog = '{10'h030, 10'h203};
    load(12'h110);
    prog = '{10'h010, 10'h204};
    load(12'h1b5);
    prog = '{10'h1c0};
    load(12'h235);
    prog = '{10'h0e5, 10'h27f};
    load(12'h240);
    prog = '{10'h1ff};
    load(12'h2ff);
    apb(1'b1, REG_PTR, 32'h300);
    apb(1'b1, REG_ACC, 32'h5);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (25) @(posedge clk);
    rd(REG_PC, 32'h010202ff);
    rd(REG_STACK, 32'h112);
    check({20'h0, rom_a}, 32'h2ff);
    $display("test 2 done");
    restart;
    prog = '{10'h29c, 10'h2a0, 10'h011, 10'h29a, 10'h29b, 10'h29f, 10'h008, 10'h005,
             10'h004, 10'h189};
    load(0);
    apb(1'b1, REG_CONV, 32'h8);
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    wdf <= 1'b1;
    @(posedge clk);
    wdf <= 1'b0;
    rd(REG_CONV, 32'h18);
    rd(REG_STATUS, 32'h10);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    rd(REG_CONV, 32'h08);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd_v, 32'h50c);
    rd(REG_PORTD, 32'h0);
    check({28'h0, wstop, ostop, rcsel, bkup}, 32'he);
    check(cmp_n, 1);
    check(conv_n, 0);
    check(res_n, 1);
    $display("test 3 done");
    wrap_up;
  end
endmodule : nibble_cpu_exec_subset_test
`default_nettype wire
